// ### core/owt_regs.vh
`ifndef OWT_REGS_VH
`define OWT_REGS_VH

// clock rate
`define OWT_CLK_MHZ 25

// line timing, time in its own unit, then cycles at the clock rate
`define OWT_RESET_LOW_US 1000
`define OWT_RESET_LOW_CYC (`OWT_RESET_LOW_US * `OWT_CLK_MHZ)
`define OWT_PRES_WAIT_US 30
`define OWT_PRES_WAIT_CYC (`OWT_PRES_WAIT_US * `OWT_CLK_MHZ)
`define OWT_PRES_LEN_US 120
`define OWT_PRES_LEN_CYC (`OWT_PRES_LEN_US * `OWT_CLK_MHZ)
`define OWT_SAMPLE_US 30
`define OWT_SAMPLE_CYC (`OWT_SAMPLE_US * `OWT_CLK_MHZ)
`define OWT_READ_HOLD_US 30
`define OWT_READ_HOLD_CYC (`OWT_READ_HOLD_US * `OWT_CLK_MHZ)
`define OWT_COPY_MS 10
`define OWT_COPY_CYC (`OWT_COPY_MS * 1000 * `OWT_CLK_MHZ)
`define OWT_RECALL_CYC 100

// command codes
`define OWT_CMD_SKIP 8'hCC
`define OWT_CMD_CONVERT 8'h44
`define OWT_CMD_READ_SP 8'hBE
`define OWT_CMD_WRITE_SP 8'h4E
`define OWT_CMD_COPY_SP 8'h48
`define OWT_CMD_RECALL 8'hB8
`define OWT_CMD_POWER 8'hB4

// scratchpad layout
`define OWT_SP_LAST 4'h8
`define OWT_WR_LAST 3'h4
`define OWT_RSVD_BYTE 8'hFF
`define OWT_CRC_POLY 8'h8C
// stored bytes 2,3,4,6,7 packed low byte first
`define OWT_NV_DEFAULT 40'h00007F464B

`endif

// ### core/owt_line_mon.v
`timescale 1ns/1ps
`default_nettype none
`include "owt_regs.vh"

module owt_line_mon #(
  parameter CW = 15,
  parameter [14:0] RESET_CYC = `OWT_RESET_LOW_CYC
)
(
  input wire clk_sys,
  input wire resetn,
  input wire dq_in,
  output reg fall,
  output reg rise,
  output reg [CW-1:0] slot_cnt,
  output reg long_low
);

  reg prev_reg;
  reg [CW-1:0] low_reg;

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      prev_reg <= 1'b1;
      fall <= 1'b0;
      rise <= 1'b0;
      slot_cnt <= {CW{1'b1}};
      low_reg <= {CW{1'b0}};
      long_low <= 1'b0;
    end
    else
    begin
      prev_reg <= dq_in;
      fall <= prev_reg & ~dq_in;
      rise <= ~prev_reg & dq_in;
      if (prev_reg & ~dq_in)
        slot_cnt <= {CW{1'b0}}; // R24
      else if (slot_cnt != {CW{1'b1}})
        slot_cnt <= slot_cnt + 1'b1;
      if (dq_in)
        low_reg <= {CW{1'b0}};
      else if (low_reg != RESET_CYC)
        low_reg <= low_reg + 1'b1;
      long_low <= ~dq_in & (low_reg >= RESET_CYC - 1'b1); // R23
    end
  end

endmodule
`default_nettype wire

// ### core/owt_nvm.v
`timescale 1ns/1ps
`default_nettype none
`include "owt_regs.vh"

module owt_nvm #(
  parameter [17:0] COPY_CYC = `OWT_COPY_CYC,
  parameter [17:0] RECALL_CYC = `OWT_RECALL_CYC
)
(
  input wire clk_sys,
  input wire resetn,
  input wire copy_req,
  input wire recall_req,
  input wire [39:0] wr_data,
  output wire [39:0] rd_data,
  output reg busy,
  output reg load
);

  reg [39:0] store_reg;
  reg [39:0] latch_reg;
  reg copy_reg;
  reg [17:0] cnt_reg;

  assign rd_data = store_reg;

  // busy out of reset: the power-up recall runs first
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      store_reg <= `OWT_NV_DEFAULT;
      latch_reg <= 40'h0000000000;
      copy_reg <= 1'b0;
      busy <= 1'b1; // R03
      cnt_reg <= 18'h00000;
      load <= 1'b0;
    end
    else
    begin
      load <= 1'b0;
      if (busy)
      begin
        if (cnt_reg == (copy_reg ? COPY_CYC : RECALL_CYC) - 1'b1)
        begin
          busy <= 1'b0;
          cnt_reg <= 18'h00000;
          if (copy_reg)
            store_reg <= latch_reg;
          else
            load <= 1'b1; // R01
        end
        else
          cnt_reg <= cnt_reg + 1'b1;
      end
      else if (copy_req)
      begin
        busy <= 1'b1;
        copy_reg <= 1'b1;
        latch_reg <= wr_data;
      end
      else if (recall_req)
      begin
        busy <= 1'b1;
        copy_reg <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ### core/owt_slave.v
// Operation
// R01: recall command reloads stored bytes 2,3,4,6,7
// R02: read slots after recall: 0 busy, 1 done
// R03: recall also runs automatically at power-up
// R04: power query slot: parasite low, external high
// R05: convert status in slots only when externally powered
// R06: scratchpad read sends up to 9 bytes
// R07: scratchpad write stores bytes into 2,3,4,6,7
// R08: master holds strong pullup during parasite operations
// R09: reset pulse aborts read, device awaits initialization
// R10: master finishes write bytes before any reset
// R11: master starts all slots, device only presence
// R12: master drives reset low at least 1 ms
// R13: presence after 15-60 us, lasting 60-240 us
// R14: exactly one bit per time slot
// R15: write slot 60 us plus 1 us recovery
// R16: write 1 released early, write 0 held low
// R17: sample 15-60 us after slot falling edge
// R18: device sends only inside master read slots
// R19: read slot starts with short low pulse
// R20: send 0 by pulling low, release by slot end
// R21: read bit valid 15 us after falling edge
// R22: master samples late in the 15 us window
// R23: low longer than 1 ms resets the link
// R24: intervals counted in cycles from each falling edge
`timescale 1ns/1ps
`default_nettype none
`include "owt_regs.vh"

module owt_slave #(
  parameter [14:0] RESET_CYC = `OWT_RESET_LOW_CYC,
  parameter [17:0] COPY_CYC = `OWT_COPY_CYC,
  parameter [17:0] RECALL_CYC = `OWT_RECALL_CYC
)
(
  input wire clk_sys,
  input wire resetn,
  input wire dq_in,
  output reg dq_out,
  output reg dq_oe_n,
  input wire parasite_mode,
  input wire conv_busy,
  input wire [15:0] temp_data,
  output reg conv_start
);

  localparam [14:0] PRES_WAIT_CYC = `OWT_PRES_WAIT_CYC;
  localparam [14:0] PRES_LEN_CYC = `OWT_PRES_LEN_CYC;
  localparam [14:0] SAMPLE_CYC = `OWT_SAMPLE_CYC;
  localparam [14:0] HOLD_CYC = `OWT_READ_HOLD_CYC;

  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_PWAIT = 4'h1;
  localparam [3:0] ST_PDRV = 4'h2;
  localparam [3:0] ST_ROM = 4'h3;
  localparam [3:0] ST_FUNC = 4'h4;
  localparam [3:0] ST_WRITE = 4'h5;
  localparam [3:0] ST_READ = 4'h6;
  localparam [3:0] ST_STAT = 4'h7;
  localparam [3:0] ST_HALT = 4'h8;

  localparam [1:0] SEL_CONV = 2'h0;
  localparam [1:0] SEL_RECALL = 2'h1;
  localparam [1:0] SEL_POWER = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // line monitor and nonvolatile store

  wire fall;
  wire rise;
  wire [14:0] slot_cnt;
  wire long_low;
  wire [39:0] nv_data;
  wire nv_busy;
  wire nv_load;

  reg [3:0] state_reg;
  reg [14:0] tmr_reg;
  reg armed_reg;
  reg live_reg;
  reg [7:0] shift_reg;
  reg [2:0] bit_reg;
  reg [3:0] byte_reg;
  reg [2:0] wr_reg;
  reg [7:0] crc_reg;
  reg [1:0] sel_reg;
  reg [39:0] user_reg;
  reg copy_req_reg;
  reg recall_req_reg;

  owt_line_mon #(
    .CW(15),
    .RESET_CYC(RESET_CYC)
  ) u_mon (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .dq_in(dq_in),
    .fall(fall),
    .rise(rise),
    .slot_cnt(slot_cnt),
    .long_low(long_low)
  );

  owt_nvm #(
    .COPY_CYC(COPY_CYC),
    .RECALL_CYC(RECALL_CYC)
  ) u_nvm (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .copy_req(copy_req_reg),
    .recall_req(recall_req_reg),
    .wr_data(user_reg),
    .rd_data(nv_data),
    .busy(nv_busy),
    .load(nv_load)
  );

  ////////////////////////////////////////////////////////////////////////
  // transmit data selection

  reg [7:0] sp_byte;
  reg stat_bit;
  reg tx_bit;
  reg [7:0] rx_byte;

  always @*
  begin
    case (byte_reg)
      4'h0: sp_byte = temp_data[7:0];
      4'h1: sp_byte = temp_data[15:8];
      4'h2: sp_byte = user_reg[7:0];
      4'h3: sp_byte = user_reg[15:8];
      4'h4: sp_byte = user_reg[23:16];
      4'h5: sp_byte = `OWT_RSVD_BYTE;
      4'h6: sp_byte = user_reg[31:24];
      4'h7: sp_byte = user_reg[39:32];
      default: sp_byte = crc_reg; // R06
    endcase
    case (sel_reg)
      SEL_CONV: stat_bit = ~conv_busy; // R05
      SEL_RECALL: stat_bit = ~nv_busy; // R02
      default: stat_bit = ~parasite_mode; // R04
    endcase
    tx_bit = (state_reg == ST_READ) ? sp_byte[bit_reg] : stat_bit;
    rx_byte = {dq_in, shift_reg[7:1]};
  end

  ////////////////////////////////////////////////////////////////////////
  // link state machine

  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= ST_IDLE;
      tmr_reg <= 15'h0000;
      armed_reg <= 1'b0;
      live_reg <= 1'b0;
      shift_reg <= 8'h00;
      bit_reg <= 3'h0;
      byte_reg <= 4'h0;
      wr_reg <= 3'h0;
      crc_reg <= 8'h00;
      sel_reg <= SEL_CONV;
      user_reg <= 40'h0000000000;
      copy_req_reg <= 1'b0;
      recall_req_reg <= 1'b0;
      dq_out <= 1'b0;
      dq_oe_n <= 1'b1;
      conv_start <= 1'b0;
    end
    else
    begin
      conv_start <= 1'b0;
      copy_req_reg <= 1'b0;
      recall_req_reg <= 1'b0;
      if (nv_load)
        user_reg <= nv_data; // R01
      if (long_low)
      begin
        // any long low drops every transfer and frees the line
        state_reg <= ST_IDLE; // R09
        armed_reg <= 1'b1; // R23
        dq_oe_n <= 1'b1;
        live_reg <= 1'b0;
      end
      else
      begin
        case (state_reg)
          ST_IDLE:
          begin
            if (armed_reg && rise)
            begin
              armed_reg <= 1'b0;
              tmr_reg <= 15'h0000;
              state_reg <= ST_PWAIT;
            end
          end
          ST_PWAIT:
          begin
            tmr_reg <= tmr_reg + 1'b1;
            if (tmr_reg == PRES_WAIT_CYC - 1'b1)
            begin
              tmr_reg <= 15'h0000;
              dq_oe_n <= 1'b0; // R13
              state_reg <= ST_PDRV;
            end
          end
          ST_PDRV:
          begin
            tmr_reg <= tmr_reg + 1'b1;
            if (tmr_reg == PRES_LEN_CYC - 1'b1)
            begin
              dq_oe_n <= 1'b1; // R13
              live_reg <= 1'b0;
              bit_reg <= 3'h0;
              state_reg <= ST_ROM;
            end
          end
          ST_ROM, ST_FUNC, ST_WRITE:
          begin
            if (fall)
              live_reg <= 1'b1; // R14
            if (live_reg && slot_cnt == SAMPLE_CYC)
            begin
              live_reg <= 1'b0;
              shift_reg <= rx_byte; // R17
              bit_reg <= bit_reg + 1'b1;
              if (bit_reg == 3'h7)
              begin
                if (state_reg == ST_ROM)
                  state_reg <= (rx_byte == `OWT_CMD_SKIP) ? ST_FUNC : ST_HALT;
                else if (state_reg == ST_WRITE)
                begin
                  user_reg[{wr_reg, 3'b000} +: 8] <= rx_byte; // R07
                  wr_reg <= wr_reg + 1'b1;
                  if (wr_reg == `OWT_WR_LAST)
                    state_reg <= ST_HALT;
                end
                else
                begin
                  byte_reg <= 4'h0;
                  crc_reg <= 8'h00;
                  wr_reg <= 3'h0;
                  case (rx_byte)
                    `OWT_CMD_READ_SP: state_reg <= ST_READ; // R18
                    `OWT_CMD_WRITE_SP: state_reg <= ST_WRITE;
                    `OWT_CMD_CONVERT:
                    begin
                      conv_start <= 1'b1;
                      sel_reg <= SEL_CONV;
                      // no status with strong pullup on the line
                      state_reg <= parasite_mode ? ST_HALT : ST_STAT; // R05
                    end
                    `OWT_CMD_COPY_SP:
                    begin
                      copy_req_reg <= 1'b1;
                      state_reg <= ST_HALT; // R08
                    end
                    `OWT_CMD_RECALL:
                    begin
                      recall_req_reg <= 1'b1; // R01
                      sel_reg <= SEL_RECALL;
                      state_reg <= ST_STAT;
                    end
                    `OWT_CMD_POWER:
                    begin
                      sel_reg <= SEL_POWER; // R04
                      state_reg <= ST_STAT;
                    end
                    default: state_reg <= ST_HALT;
                  endcase
                end
              end
            end
          end
          ST_READ, ST_STAT:
          begin
            if (fall)
            begin
              // answer only on a master falling edge
              dq_oe_n <= tx_bit; // R20 R11
              if (state_reg == ST_READ)
              begin
                bit_reg <= bit_reg + 1'b1;
                if (byte_reg != `OWT_SP_LAST)
                  crc_reg <= (crc_reg >> 1) ^
                    ((crc_reg[0] ^ tx_bit) ? `OWT_CRC_POLY : 8'h00);
                if (bit_reg == 3'h7)
                  byte_reg <= byte_reg + 1'b1;
              end
            end
            else if (slot_cnt == HOLD_CYC)
            begin
              dq_oe_n <= 1'b1; // R21
              if (state_reg == ST_READ && byte_reg > `OWT_SP_LAST)
                state_reg <= ST_HALT; // R06
            end
          end
          ST_HALT:
          begin
            dq_oe_n <= 1'b1;
          end
          default:
          begin
            state_reg <= ST_IDLE;
            dq_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ### test/owt_slave_sva.sv
`timescale 1ns/1ps
`default_nettype none
module owt_slave_sva #(
  parameter [14:0] RESET_CYC = 15'h61A8
)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic dq_in,
  input wire logic dq_out,
  input wire logic dq_oe_n,
  input wire logic parasite_mode,
  input wire logic conv_busy,
  input wire logic [15:0] temp_data,
  input wire logic conv_start
);
  logic [15:0] low_cnt;
  logic [12:0] pres_cnt;
  logic [12:0] oe_len;
  logic [10:0] fall_cnt;
  logic dq_prev;
  logic pres_hit;
  wire logic rst_rise;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  assign rst_rise = dq_in && (low_cnt >= RESET_CYC);
  // saturating, so long idle spans never wrap into a false window
  always @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      low_cnt <= 16'h0000;
      pres_cnt <= 13'h1F40;
      oe_len <= 13'h0000;
      fall_cnt <= 11'h7FF;
      dq_prev <= 1'b1;
      pres_hit <= 1'b0;
    end
    else
    begin
      dq_prev <= dq_in;
      // counted window instead of a long delay range
      pres_hit <= rst_rise ? 1'b0 : (pres_hit | !dq_oe_n);
      low_cnt <= dq_in ? 16'h0000 : low_cnt + 16'(low_cnt != 16'hFFFF);
      pres_cnt <= rst_rise ? 13'h0001 : pres_cnt + 13'(pres_cnt != 13'h1F40);
      oe_len <= dq_oe_n ? 13'h0000 : oe_len + 13'(oe_len != 13'h1FFF);
      fall_cnt <= (dq_prev && !dq_in) ? 11'h000 :
        fall_cnt + 11'(fall_cnt != 11'h7FF);
    end
  end
  ////////////////////////////////////////
  a_out_low: assert property (dq_out == 1'b0)
    else $error("line drive value not zero");
  a_reset_idle: assert property ($rose(resetn) |-> dq_oe_n && !conv_start)
    else $error("outputs active after reset");
  a_pres_wait: assert property ((pres_cnt > 0 && pres_cnt < 375) |-> dq_oe_n)
    else $error("presence too early");
  a_pres_start: assert property ((pres_cnt == 13'h05DC) |-> pres_hit)
    else $error("presence missing");
  a_pres_len: assert property (($rose(dq_oe_n) && pres_cnt < 13'h1F40) |-> oe_len >= 1500)
    else $error("presence too short");
  a_drive_max: assert property (!dq_oe_n |-> oe_len < 13'h1770)
    else $error("line held low too long");
  a_read_hold: assert property (($rose(dq_oe_n) && pres_cnt == 13'h1F40)
    |-> (fall_cnt >= 375 && fall_cnt <= 1500))
    else $error("read zero released out of window");
  a_read_start: assert property (($fell(dq_oe_n) && pres_cnt == 13'h1F40)
    |-> fall_cnt <= 4)
    else $error("drive outside a read slot");
  a_long_low: assert property ((low_cnt > RESET_CYC + 4) |-> dq_oe_n)
    else $error("line held during long low");
  a_conv_pulse: assert property (conv_start |=> !conv_start)
    else $error("conversion start not a pulse");
  c_pres: cover property (pres_cnt == 13'h05DC && pres_hit);
  c_read0: cover property ($fell(dq_oe_n) && pres_cnt == 13'h1F40);
  c_conv: cover property (conv_start);
endmodule
bind owt_slave owt_slave_sva #(.RESET_CYC(RESET_CYC)) u_sva (
  .clk_sys(clk_sys),
  .resetn(resetn),
  .dq_in(dq_in),
  .dq_out(dq_out),
  .dq_oe_n(dq_oe_n),
  .parasite_mode(parasite_mode),
  .conv_busy(conv_busy),
  .temp_data(temp_data),
  .conv_start(conv_start)
);
`default_nettype wire

// ### test/owt_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module owt_master_model
(
  input wire logic clk_sys,
  input wire logic dq_line,
  output logic mst_low
);
  // slots cut to just past the device sample point to keep runs short
  localparam int SLOT = 770;
  initial mst_low = 1'b0;
  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic line_reset(output logic seen);
    seen = 1'b0;
    @(posedge clk_sys);
    mst_low <= 1'b1;
    // must outlast the bench reset threshold of 3400 cycles
    hold(3500);
    mst_low <= 1'b0;
    repeat (3800)
    begin
      @(posedge clk_sys);
      if (dq_line === 1'b0) seen = 1'b1;
    end
  endtask
  task automatic slot(input logic wbit, output logic rbit);
    @(posedge clk_sys);
    mst_low <= 1'b1;
    hold(25);
    if (wbit) mst_low <= 1'b0;
    hold(225);
    rbit = dq_line;
    hold(SLOT - 250);
    mst_low <= 1'b0;
    hold(25);
  endtask
  task automatic send_byte(input logic [7:0] v);
    logic r;
    for (int i = 0; i < 8; i++) slot(v[i], r);
  endtask
  task automatic get_bit(output logic r);
    slot(1'b1, r);
  endtask
  task automatic get_byte(output logic [7:0] v);
    for (int i = 0; i < 8; i++) slot(1'b1, v[i]);
  endtask
endmodule
`default_nettype wire

// ### test/one_wire_temp_slave_signaling_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "owt_regs.vh"
module one_wire_temp_slave_signaling_bench;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic parasite_mode = 1'b0;
  logic conv_busy = 1'b0;
  logic [15:0] temp_data = 16'h0000;
  integer conv_cnt = 0;
  integer conv_base;
  wire logic dq_out;
  wire logic dq_oe_n;
  wire logic conv_start;
  wire logic mst_low;
  wire logic dq_line;
  integer seed;
  integer error_cnt = 0;
  integer compares = 0;
  logic [31:0] r;
  logic [7:0] rb [0:4];
  logic [7:0] wr [0:2];
  logic b;
  // released line floats high through the pullup
  assign dq_line = dq_oe_n && !mst_low;
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (conv_start === 1'b1) conv_cnt <= conv_cnt + 1;
  // reset threshold above presence (3000) and write-0 slot lengths
  owt_slave #(.RESET_CYC(15'h0D48), .COPY_CYC(18'h00032),
    .RECALL_CYC(18'h003E8)) DUT (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .dq_in(dq_line),
    .dq_out(dq_out),
    .dq_oe_n(dq_oe_n),
    .parasite_mode(parasite_mode),
    .conv_busy(conv_busy),
    .temp_data(temp_data),
    .conv_start(conv_start)
  );
  owt_master_model M (
    .clk_sys(clk_sys),
    .dq_line(dq_line),
    .mst_low(mst_low)
  );
  ////////////////////////////////////////
  function automatic logic [7:0] nv_byte(input int k);
    return 8'(`OWT_NV_DEFAULT >> (8 * k));
  endfunction
  function automatic logic [7:0] pwr_bit(input logic p);
    return {7'h00, !p};
  endfunction
  task automatic tally_and_finish();
    if (error_cnt == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares = compares + 1;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt = error_cnt + 1;
    end
  endtask
  task automatic open_cmd(input logic [7:0] cmd);
    logic seen;
    M.line_reset(seen);
    check({7'h00, seen}, 8'h01);
    M.send_byte(`OWT_CMD_SKIP);
    M.send_byte(cmd);
  endtask
  task automatic read_n(input int n);
    for (int i = 0; i < n; i++) M.get_byte(rb[i]);
  endtask
  initial
  begin
    #12000000;
    error_cnt = error_cnt + 1;
    tally_and_finish();
  end
  initial
  begin
    seed = 32'hF4A5;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    r = $random(seed);
    temp_data <= r[15:0];
    wr[0] = 8'h00;
    wr[1] = 8'hFF;
    wr[2] = r[23:16];
    open_cmd(`OWT_CMD_WRITE_SP);
    for (int i = 0; i < 3; i++) M.send_byte(wr[i]);
    open_cmd(`OWT_CMD_READ_SP);
    read_n(5);
    check(rb[0], temp_data[7:0]);
    check(rb[1], temp_data[15:8]);
    for (int i = 0; i < 3; i++) check(rb[i + 2], wr[i]);
    // read left after five bytes, next reset must still be answered
    open_cmd(`OWT_CMD_RECALL);
    M.get_bit(b);
    check({7'h00, b}, 8'h00);
    M.get_bit(b);
    M.get_bit(b);
    check({7'h00, b}, 8'h01);
    open_cmd(`OWT_CMD_READ_SP);
    read_n(5);
    for (int i = 0; i < 3; i++) check(rb[i + 2], nv_byte(i));
    r = $random(seed);
    parasite_mode <= r[0];
    open_cmd(`OWT_CMD_POWER);
    M.get_bit(b);
    check({7'h00, b}, pwr_bit(parasite_mode));
    parasite_mode <= 1'b0;
    conv_busy <= 1'b1;
    conv_base = conv_cnt;
    open_cmd(`OWT_CMD_CONVERT);
    check(8'(conv_cnt - conv_base), 8'h01);
    M.get_bit(b);
    check({7'h00, b}, 8'h00);
    conv_busy <= 1'b0;
    M.get_bit(b);
    check({7'h00, b}, 8'h01);
    tally_and_finish();
  end
endmodule
`default_nettype wire
